// file: rtl/rx_dec_consts.vh
// Constants for the receive 8B/10B decode stage and receiver state machine.
// Assumes inclusion by bare name from the rtl/ directory.
`ifndef RX_DEC_CONSTS_VH
`define RX_DEC_CONSTS_VH

// Functional mode codes on MODE_SEL
`define MODE_BASIC      3'h0
`define MODE_GIGE       3'h1
`define MODE_PIPE       3'h2
`define MODE_XAUI       3'h3
`define MODE_SRIO       3'h4
`define MODE_SDI        3'h5

// Running disparity encoding and reset value
`define RD_NEG          1'b0
`define RD_POS          1'b1
`define RD_RESET        1'b0

// Special 6b and 4b sub-blocks
`define K28_NEG_6B      6'h0F
`define K28_POS_6B      6'h30
`define D07_NEG_6B      6'h38
`define D07_POS_6B      6'h07
`define X3_NEG_4B       4'hC
`define X3_POS_4B       4'h3
`define P7_NEG_4B       4'hE
`define P7_POS_4B       4'h1
`define A7_NEG_4B       4'h7
`define A7_POS_4B       4'h8

// Character values
`define CHAR_K28_0      8'h1C
`define CHAR_K28_3      8'h7C
`define CHAR_K28_5      8'hBC
`define CHAR_K30_7      8'hFE
`define XGMII_IDLE      8'h07
`define XGMII_ERROR     8'hFE

// Pipeline depth from CODE_IN to DATA_OUT, in clock cycles
`define DECODE_LATENCY  2

`endif

// file: rtl/rx_8b10b_decode_state_machine.v
// Receive 8B/10B decoder with mode-dependent receiver state machine.
// Assumes code groups arrive from the rate matcher on CLK_SYS, the parallel
// recovered clock, bit 9 = a (first bit) down to bit 0 = j.
`include "rx_dec_consts.vh"
`timescale 1ns/1ps
`default_nettype none

// Function
// R01 - Each 10-bit code group is decoded into an 8-bit value plus a 1-bit control indicator.
// R02 - The decoder works in every functional mode whatever protocol is chosen.
// R03 - The control indicator is high for a Kx.y group and low for a Dx.y group.
// R04 - A group outside both the data and control code sets raises the code error flag.
// R05 - A group with wrong running disparity raises both the disparity and the code error flag.
// R06 - Both error flags travel with the same latency as their group and leave with its data.
// R07 - The state machine acts only in Basic, gigabit Ethernet, PIPE and XAUI modes; else data passes.
// R08 - In gigabit Ethernet mode an invalid group is replaced by K30.7.
// R09 - In XAUI mode each PCS code group is mapped to its XGMII code group.
// R10 - All of this logic runs on the parallel recovered clock; the deserializer uses the serial one.
// R11 - A running disparity is kept, updated after each group, and checked against the standard tables.
// R12 - Downstream logic samples data, control and error flags together as one aligned word.
module rx_8b10b_decode_state_machine (
  input  wire       CLK_SYS,
  input  wire       RST_N,
  input  wire [9:0] CODE_IN,
  input  wire       CODE_VALID,
  input  wire [2:0] MODE_SEL,
  output reg  [7:0] DATA_OUT,
  output reg        CTRL_OUT,
  output reg        CODE_ERR,
  output reg        DISP_ERR,
  output reg        DATA_VALID
);

  // 6b sub-block to EDCBA; bit 5 marks a valid data code
  function [5:0] dec6;
    input [5:0] c;
    begin
      case (c)
        6'h27:        dec6 = {1'b1, 5'd0};
        6'h18:        dec6 = {1'b1, 5'd0};
        6'h1D:        dec6 = {1'b1, 5'd1};
        6'h22:        dec6 = {1'b1, 5'd1};
        6'h2D:        dec6 = {1'b1, 5'd2};
        6'h12:        dec6 = {1'b1, 5'd2};
        6'h31:        dec6 = {1'b1, 5'd3};
        6'h35:        dec6 = {1'b1, 5'd4};
        6'h0A:        dec6 = {1'b1, 5'd4};
        6'h29:        dec6 = {1'b1, 5'd5};
        6'h19:        dec6 = {1'b1, 5'd6};
        6'h38:        dec6 = {1'b1, 5'd7};
        6'h07:        dec6 = {1'b1, 5'd7};
        6'h39:        dec6 = {1'b1, 5'd8};
        6'h06:        dec6 = {1'b1, 5'd8};
        6'h25:        dec6 = {1'b1, 5'd9};
        6'h15:        dec6 = {1'b1, 5'd10};
        6'h34:        dec6 = {1'b1, 5'd11};
        6'h0D:        dec6 = {1'b1, 5'd12};
        6'h2C:        dec6 = {1'b1, 5'd13};
        6'h1C:        dec6 = {1'b1, 5'd14};
        6'h17:        dec6 = {1'b1, 5'd15};
        6'h28:        dec6 = {1'b1, 5'd15};
        6'h1B:        dec6 = {1'b1, 5'd16};
        6'h24:        dec6 = {1'b1, 5'd16};
        6'h23:        dec6 = {1'b1, 5'd17};
        6'h13:        dec6 = {1'b1, 5'd18};
        6'h32:        dec6 = {1'b1, 5'd19};
        6'h0B:        dec6 = {1'b1, 5'd20};
        6'h2A:        dec6 = {1'b1, 5'd21};
        6'h1A:        dec6 = {1'b1, 5'd22};
        6'h3A:        dec6 = {1'b1, 5'd23};
        6'h05:        dec6 = {1'b1, 5'd23};
        6'h33:        dec6 = {1'b1, 5'd24};
        6'h0C:        dec6 = {1'b1, 5'd24};
        6'h26:        dec6 = {1'b1, 5'd25};
        6'h16:        dec6 = {1'b1, 5'd26};
        6'h36:        dec6 = {1'b1, 5'd27};
        6'h09:        dec6 = {1'b1, 5'd27};
        6'h0E:        dec6 = {1'b1, 5'd28};
        6'h2E:        dec6 = {1'b1, 5'd29};
        6'h11:        dec6 = {1'b1, 5'd29};
        6'h1E:        dec6 = {1'b1, 5'd30};
        6'h21:        dec6 = {1'b1, 5'd30};
        6'h2B:        dec6 = {1'b1, 5'd31};
        6'h14:        dec6 = {1'b1, 5'd31};
        default:      dec6 = {1'b0, 5'd0};
      endcase
    end
  endfunction

  // 4b sub-block to HGF; bit 3 marks a valid code
  function [3:0] dec4;
    input [3:0] c;
    begin
      case (c)
        4'hB:                   dec4 = {1'b1, 3'd0};
        4'h4:                   dec4 = {1'b1, 3'd0};
        4'h9:                   dec4 = {1'b1, 3'd1};
        4'h5:                   dec4 = {1'b1, 3'd2};
        4'hC:                   dec4 = {1'b1, 3'd3};
        4'h3:                   dec4 = {1'b1, 3'd3};
        4'hD:                   dec4 = {1'b1, 3'd4};
        4'h2:                   dec4 = {1'b1, 3'd4};
        4'hA:                   dec4 = {1'b1, 3'd5};
        4'h6:                   dec4 = {1'b1, 3'd6};
        4'hE:                   dec4 = {1'b1, 3'd7};
        4'h1:                   dec4 = {1'b1, 3'd7};
        4'h7:                   dec4 = {1'b1, 3'd7};
        4'h8:                   dec4 = {1'b1, 3'd7};
        default:                dec4 = {1'b0, 3'd0};
      endcase
    end
  endfunction

  function [2:0] ones6;
    input [5:0] c;
    begin
      ones6 = {2'b00, c[0]} + {2'b00, c[1]} + {2'b00, c[2]}
            + {2'b00, c[3]} + {2'b00, c[4]} + {2'b00, c[5]};
    end
  endfunction

  function [2:0] ones4;
    input [3:0] c;
    begin
      ones4 = {2'b00, c[0]} + {2'b00, c[1]} + {2'b00, c[2]} + {2'b00, c[3]};
    end
  endfunction

  reg        rd_q;
  reg        rd_d;
  reg  [7:0] dec_data_q;
  reg        dec_ctrl_q;
  reg        dec_cerr_q;
  reg        dec_derr_q;
  reg        dec_valid_q;

  wire [5:0] c6     = CODE_IN[9:4];
  wire [3:0] c4     = CODE_IN[3:0];
  wire       bit_e  = CODE_IN[5];
  wire       bit_i  = CODE_IN[4];
  wire       k28    = (c6 == `K28_NEG_6B) || (c6 == `K28_POS_6B);
  wire [3:0] c4n    = (c6 == `K28_POS_6B) ? ~c4 : c4;
  wire [5:0] f6     = dec6(c6);
  wire [3:0] f4     = dec4(c4n);
  wire [4:0] x5     = k28 ? 5'd28 : f6[4:0];
  wire       v6     = f6[5] | k28;
  wire       is_p7  = (c4n == `P7_NEG_4B) || (c4n == `P7_POS_4B);
  wire       is_a7  = (c4n == `A7_NEG_4B) || (c4n == `A7_POS_4B);
  wire       kx7    = (x5 == 5'd23) || (x5 == 5'd27) || (x5 == 5'd29) || (x5 == 5'd30);
  wire       k_alt  = is_a7 && (bit_e ^ bit_i) && kx7 && f6[5] && !k28;
  wire       is_k   = k28 || k_alt;
  wire       a7_ok  = (bit_e && bit_i && (c4 == `A7_NEG_4B)) || (!bit_e && !bit_i && (c4 == `A7_POS_4B));
  wire       p7_bad = k28 || (bit_e && bit_i && (c4 == `P7_NEG_4B)) || (!bit_e && !bit_i && (c4 == `P7_POS_4B));
  wire [2:0] n6     = ones6(c6);
  wire [2:0] n4     = ones4(c4);

  // Running disparity through both sub-blocks
  reg rd_mid;
  reg derr;
  reg cerr;
  always @* begin
    derr   = 1'b0;
    rd_mid = rd_q;
    if (n6 > 3'd3) begin
      derr   = (rd_q == `RD_POS);                                           // see R11
      rd_mid = `RD_POS;
    end else if (n6 < 3'd3) begin
      derr   = (rd_q == `RD_NEG);                                           // see R11
      rd_mid = `RD_NEG;
    end else if ((c6 == `D07_NEG_6B) && (rd_q == `RD_POS)) begin
      derr   = 1'b1;
    end else if ((c6 == `D07_POS_6B) && (rd_q == `RD_NEG)) begin
      derr   = 1'b1;
    end
    rd_d = rd_mid;
    if (n4 > 3'd2) begin
      derr = derr | (rd_mid == `RD_POS);                                    // see R11
      rd_d = `RD_POS;
    end else if (n4 < 3'd2) begin
      derr = derr | (rd_mid == `RD_NEG);                                    // see R11
      rd_d = `RD_NEG;
    end else if ((c4 == `X3_NEG_4B) && (rd_mid == `RD_POS)) begin
      derr = 1'b1;
    end else if ((c4 == `X3_POS_4B) && (rd_mid == `RD_NEG)) begin
      derr = 1'b1;
    end
    cerr = !v6 || !f4[3] || (is_p7 && p7_bad)                               // see R04
         || (is_a7 && !k28 && !k_alt && !a7_ok) || derr;                    // see R05
  end

  // Decode stage, active in every mode
  always @(posedge CLK_SYS) begin                                           // see R10
    if (!RST_N) begin
      rd_q        <= `RD_RESET;
      dec_data_q  <= 8'h00;
      dec_ctrl_q  <= 1'b0;
      dec_cerr_q  <= 1'b0;
      dec_derr_q  <= 1'b0;
      dec_valid_q <= 1'b0;
    end else begin
      dec_valid_q <= CODE_VALID;                                            // see R02
      if (CODE_VALID) begin
        rd_q       <= rd_d;                                                 // see R11
        dec_data_q <= {f4[2:0], x5};                                        // see R01
        dec_ctrl_q <= is_k;                                                 // see R03
        dec_cerr_q <= cerr;                                                 // see R04
        dec_derr_q <= derr;                                                 // see R05
      end
    end
  end

  // Receiver state machine stage
  wire sm_active = (MODE_SEL == `MODE_BASIC) || (MODE_SEL == `MODE_GIGE)
                || (MODE_SEL == `MODE_PIPE)  || (MODE_SEL == `MODE_XAUI);   // see R07
  reg [7:0] sm_data;
  reg       sm_ctrl;
  always @* begin
    sm_data = dec_data_q;
    sm_ctrl = dec_ctrl_q;
    if (sm_active) begin
      case (MODE_SEL)
        `MODE_GIGE: begin
          if (dec_cerr_q) begin
            sm_data = `CHAR_K30_7;                                          // see R08
            sm_ctrl = 1'b1;
          end
        end
        `MODE_XAUI: begin
          if (dec_cerr_q) begin
            sm_data = `XGMII_ERROR;                                         // see R09
            sm_ctrl = 1'b1;
          end else if (dec_ctrl_q && ((dec_data_q == `CHAR_K28_5) ||
                   (dec_data_q == `CHAR_K28_0) || (dec_data_q == `CHAR_K28_3))) begin
            sm_data = `XGMII_IDLE;                                          // see R09
          end
        end
        `MODE_BASIC: begin
          // Active, no substitution
          sm_data = dec_data_q;
          sm_ctrl = dec_ctrl_q;
        end
        `MODE_PIPE: begin
          // Active, no substitution
          sm_data = dec_data_q;
          sm_ctrl = dec_ctrl_q;
        end
        default: begin
          sm_data = dec_data_q;
          sm_ctrl = dec_ctrl_q;
        end
      endcase
    end
  end

  // Output stage; flags ride with their group
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      DATA_OUT   <= 8'h00;
      CTRL_OUT   <= 1'b0;
      CODE_ERR   <= 1'b0;
      DISP_ERR   <= 1'b0;
      DATA_VALID <= 1'b0;
    end else begin
      DATA_VALID <= dec_valid_q;
      if (dec_valid_q) begin
        DATA_OUT <= sm_data;
        CTRL_OUT <= sm_ctrl;
        CODE_ERR <= dec_cerr_q;                                             // see R06
        DISP_ERR <= dec_derr_q;                                             // see R06
      end
    end
  end

endmodule // rx_8b10b_decode_state_machine

`default_nettype wire

// file: sim/rate_matcher_model.sv
// Stand-in for the upstream rate matcher.
// Assumes requests change just after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module rate_matcher_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [9:0] grp,
  output var  logic [9:0] code,
  output var  logic       valid
);
  initial begin
    code  = 10'h155;
    valid = 1'b0;
  end
  always @(posedge clk) begin
    valid <= go;
    code  <= go ? grp : ~code; // Idle bus inverts every bit of the last code each cycle
  end
endmodule // rate_matcher_model
`default_nettype wire

// file: sim/rx_dec_monitor.sv
// Port checks for the receive decoder.
// Assumes MODE_SEL changes only in reset or idle.
`include "rx_dec_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module rx_dec_monitor (
  input wire logic       CLK_SYS,
  input wire logic       RST_N,
  input wire logic [9:0] CODE_IN,
  input wire logic       CODE_VALID,
  input wire logic [2:0] MODE_SEL,
  input wire logic [7:0] DATA_OUT,
  input wire logic       CTRL_OUT,
  input wire logic       CODE_ERR,
  input wire logic       DISP_ERR,
  input wire logic       DATA_VALID
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence s_take(logic [9:0] g);
    CODE_VALID && CODE_IN == g;
  endsequence
  sequence s_word(logic [7:0] d, logic k);
    DATA_VALID && DATA_OUT == d && CTRL_OUT == k;
  endsequence
  chk_valid_lat: assert property (CODE_VALID |-> ##2 DATA_VALID)
    else $error("group not delivered after two cycles");
  chk_no_spur: assert property (!CODE_VALID |-> ##2 !DATA_VALID)
    else $error("output without a group");
  chk_k_char: assert property (s_take(10'h0FA) ##0 MODE_SEL != `MODE_GIGE && MODE_SEL != `MODE_XAUI
    |-> ##2 s_word(8'hBC, 1'b1)) else $error("control group misdecoded");
  chk_d_char: assert property (s_take(10'h2AA) |-> ##2 s_word(8'hB5, 1'b0) ##0 !CODE_ERR)
    else $error("data group misdecoded");
  chk_bad_code: assert property (s_take(10'h000) |-> ##2 DATA_VALID && CODE_ERR)
    else $error("invalid group not flagged");
  chk_disp_pair: assert property (DISP_ERR |-> CODE_ERR)
    else $error("disparity error without code error");
  chk_gige_sub: assert property (DATA_VALID && CODE_ERR && MODE_SEL == `MODE_GIGE
    |-> DATA_OUT == `CHAR_K30_7 && CTRL_OUT) else $error("errored group not replaced");
  chk_xaui_map: assert property (s_take(10'h0FA) ##0 MODE_SEL == `MODE_XAUI |-> ##2 DATA_VALID && CTRL_OUT
    && DATA_OUT == (CODE_ERR ? `XGMII_ERROR : `XGMII_IDLE)) else $error("comma not mapped");
  chk_out_hold: assert property (!DATA_VALID |-> $stable(DATA_OUT) && $stable(CODE_ERR))
    else $error("outputs moved without a group");
endmodule // rx_dec_monitor
bind rx_8b10b_decode_state_machine rx_dec_monitor rx_dec_monitor_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .CODE_IN(CODE_IN), .CODE_VALID(CODE_VALID), .MODE_SEL(MODE_SEL), .DATA_OUT(DATA_OUT),
  .CTRL_OUT(CTRL_OUT), .CODE_ERR(CODE_ERR), .DISP_ERR(DISP_ERR), .DATA_VALID(DATA_VALID));
`default_nettype wire

// file: sim/test_rx_8b10b_decode_state_machine.sv
// Self-checking bench for the receive decoder.
// Assumes the rate matcher model and checker are compiled first.
`include "rx_dec_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module test_rx_8b10b_decode_state_machine;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        go      = 1'b0;
  logic [9:0]  grp     = 10'h000;
  logic [2:0]  mode    = `MODE_BASIC;
  logic [9:0]  code;
  logic        valid;
  wire  [7:0]  data_out;
  wire         ctrl_out;
  wire         code_err;
  wire         disp_err;
  wire         data_valid;
  logic [10:0] got[$];
  int          error_cnt = 0;
  int          n_checks  = 0;
  always #2 clk_sys = ~clk_sys;
  rate_matcher_model rate_matcher_model_inst (.clk(clk_sys), .go(go), .grp(grp), .code(code), .valid(valid));
  rx_8b10b_decode_state_machine rx_8b10b_decode_state_machine_inst (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .CODE_IN(code), .CODE_VALID(valid), .MODE_SEL(mode), .DATA_OUT(data_out), .CTRL_OUT(ctrl_out),
    .CODE_ERR(code_err), .DISP_ERR(disp_err), .DATA_VALID(data_valid));
  // Downstream takes the word as one aligned unit
  always @(posedge clk_sys) if (data_valid === 1'b1) got.push_back({data_out, ctrl_out, code_err, disp_err});
  task automatic check(input logic [10:0] seen, input logic [10:0] exp, input logic [10:0] mask);
    n_checks++;
    if ((seen & mask) !== (exp & mask)) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset(input logic [2:0] m);
    rst_n <= 1'b0;
    mode  <= m;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    got.delete();
  endtask
  task automatic send3(input logic [9:0] g0, input logic [9:0] g1, input logic [9:0] g2);
    int n;
    go  <= 1'b1;
    grp <= g0;
    @(posedge clk_sys) grp <= g1;
    @(posedge clk_sys) grp <= g2;
    @(posedge clk_sys) go <= 1'b0;
    n = 0;
    while (got.size() < 3 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic t_basic;
    do_reset(`MODE_BASIC);
    send3(10'h0FA, 10'h2AA, 10'h305);
    check(got[0], {8'hBC, 3'b100}, 11'h7FF);
    check(got[1], {8'hB5, 3'b000}, 11'h7FF);
    check(got[2], {8'hBC, 3'b100}, 11'h7FF);
    $display("test basic done");
  endtask
  task automatic t_modes;
    logic sub;
    for (int m = 0; m < 6; m++) begin
      do_reset(m[2:0]);
      sub = (m[2:0] == `MODE_GIGE) || (m[2:0] == `MODE_XAUI);
      send3(10'h0FA, 10'h0FA, 10'h000);
      check(got[0], {(m[2:0] == `MODE_XAUI) ? 8'h07 : 8'hBC, 3'b100}, 11'h7FF);
      check(got[1], {sub ? 8'hFE : 8'hBC, 3'b111}, 11'h7FF);
      check(got[2], {sub ? 8'hFE : 8'h00, sub, 2'b11}, 11'h7FF);
    end
    $display("test modes done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end
  initial begin
    t_basic();
    t_modes();
    results();
  end
endmodule // test_rx_8b10b_decode_state_machine
`default_nettype wire
